// ===== rtl/ioc_pkg.sv
// package for the internal oscillator and system clock select block
// assumes a single 100 MHz bus clock; oscillator rates are enable pulses
package ioc_pkg;

   // bus clock and nominal oscillator rate, in kHz
   localparam int PCLK_KHZ = 100000;
   localparam int OSC_NOMINAL_KHZ = 24500;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_SRC_SEL = 8'hA9;
   localparam logic [7:0] IDX_OSC_CTRL = 8'hB2;
   localparam logic [7:0] IDX_OSC_CAL = 8'hB4;
   localparam logic [7:0] IDX_IRQ_STS = 8'hB5;
   localparam logic [7:0] IDX_IRQ_MSK = 8'hB6;
   localparam int APB_AW = 12;
   localparam logic [1:0] ADDR_PAD = 2'h0;
   localparam logic [APB_AW-1:0] ADDR_SRC_SEL = {ADDR_PAD, IDX_SRC_SEL, ADDR_PAD};
   localparam logic [APB_AW-1:0] ADDR_OSC_CTRL = {ADDR_PAD, IDX_OSC_CTRL, ADDR_PAD};
   localparam logic [APB_AW-1:0] ADDR_OSC_CAL = {ADDR_PAD, IDX_OSC_CAL, ADDR_PAD};
   localparam logic [APB_AW-1:0] ADDR_IRQ_STS = {ADDR_PAD, IDX_IRQ_STS, ADDR_PAD};
   localparam logic [APB_AW-1:0] ADDR_IRQ_MSK = {ADDR_PAD, IDX_IRQ_MSK, ADDR_PAD};

   // field positions
   localparam int OSC_EN_BIT = 7;
   localparam int OSC_RDY_BIT = 6;
   localparam int SRC_BIT = 0;
   localparam int IRQ_RDY = 0;
   localparam int IRQ_SWITCH = 1;
   localparam int IRQ_W = 2;

   // reset values
   localparam logic [7:0] RST_OSC_CTRL = 8'hC0;
   localparam logic [7:0] RST_SRC_SEL = 8'h00;

   // calibration: oscillator tick every cal+1 bus clocks
   localparam int CAL_W = 7;
   localparam logic [CAL_W-1:0] CAL_NOMINAL = CAL_W'(PCLK_KHZ / OSC_NOMINAL_KHZ - 1);

   // oscillator ticks counted before the ready flag rises
   localparam logic [3:0] SETTLE_TICKS = 4'h8;

   // divide field encoding
   typedef enum logic [1:0] {
      DIV_BY_8 = 2'h0,
      DIV_BY_4 = 2'h1,
      DIV_BY_2 = 2'h2,
      DIV_BY_1 = 2'h3
   } ioc_div_t;

   // divider masks: tick when low count bits are all ones
   localparam logic [2:0] MASK_8 = 3'h7;
   localparam logic [2:0] MASK_4 = 3'h3;
   localparam logic [2:0] MASK_2 = 3'h1;
   localparam logic [2:0] MASK_1 = 3'h0;

   // state of the tick divider
   typedef struct packed {
      logic [CAL_W-1:0] cnt;
      logic tick;
   } ioc_div_state_t;

   // state of the clock control block
   typedef struct packed {
      logic osc_en;
      ioc_div_t div;
      logic src_sel;
      logic [CAL_W-1:0] cal;
      ioc_div_t div_act;
      logic src_act;
      logic rdy;
      logic [3:0] settle;
      logic [2:0] dcnt;
      logic [IRQ_W-1:0] sts;
      logic [IRQ_W-1:0] msk;
      logic [31:0] rdata;
      logic sys_en;
   } ioc_state_t;

endpackage

// ===== rtl/ioc_system_clock_ctrl.sv
// system clock control: internal oscillator enable, calibration, divide
// and glitch-free selection between internal and external sources
// assumes ext_osc_tick is a one-cycle pulse per external clock period
//
// Summary of operation
// - after reset the system clock runs from the internal oscillator
// - calibration register sets oscillator period; reset loads CAL_FACTORY, the nominal value by default
// - internal system clock is oscillator divided by 1, 2, 4 or 8
// - reset loads divide field for divide by 8
// - control bit 7 enables the oscillator; resets to one
// - source is external or internal, the internal one undivided or divided
// - select bit 0 chooses the source; resets to internal
// - select zero gives internal oscillator scaled by divide field
// - select bits 7 to 1 read zero; writes to them ignored
// - select one switches the system clock to the external source
// - source switching is glitch-free, on a tick of the current source or at once from a stopped internal one; the new source is not checked for running
`timescale 1ns/1ps
module ioc_system_clock_ctrl
   import ioc_pkg::*;
#(
   parameter logic [CAL_W-1:0] CAL_FACTORY = CAL_NOMINAL
)
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // external oscillator circuit
   input wire logic ext_osc_tick,
   // system clock enable and status
   output logic system_clock_en,
   output logic system_clock_from_ext,
   output logic irq
);

   ioc_state_t q;
   ioc_state_t next_q;

   logic osc_tick;
   logic osc_restart;
   logic acc;
   logic wr;
   logic mapped;
   logic [31:0] rd;
   logic [2:0] mask;
   logic int_tick;
   logic cur_tick;
   logic [IRQ_W-1:0] ev;

   // bus phases
   assign acc = psel && penable;
   assign wr = acc && pwrite;

   // a calibration write restarts the oscillator so the new period
   // is settled from a clean count
   assign osc_restart = wr && (paddr == ADDR_OSC_CAL);

   ioc_tick_div u_osc (
      .clk(pclk),
      .rst_n(presetn),
      .en(q.osc_en),
      .restart(osc_restart),
      .period(q.cal),
      .tick(osc_tick)
   );

   always_comb begin
      case (q.div_act)
         DIV_BY_8: mask = MASK_8;
         DIV_BY_4: mask = MASK_4;
         DIV_BY_2: mask = MASK_2;
         default: mask = MASK_1;
      endcase
   end

   // divided internal tick; select zero uses it
   assign int_tick = osc_tick && ((q.dcnt & mask) == mask);
   assign cur_tick = q.src_act ? ext_osc_tick : int_tick;

   // register read decode; unmapped addresses answer with an error
   always_comb begin
      rd = 32'h0;
      mapped = 1'b1;
      if (paddr == ADDR_SRC_SEL) begin
         rd[SRC_BIT] = q.src_sel;
      end else if (paddr == ADDR_OSC_CTRL) begin
         rd[OSC_EN_BIT] = q.osc_en;
         rd[OSC_RDY_BIT] = q.rdy;
         rd[1:0] = q.div;
      end else if (paddr == ADDR_OSC_CAL) begin
         rd[CAL_W-1:0] = q.cal;
      end else if (paddr == ADDR_IRQ_STS) begin
         rd[IRQ_W-1:0] = q.sts;
      end else if (paddr == ADDR_IRQ_MSK) begin
         rd[IRQ_W-1:0] = q.msk;
      end else begin
         mapped = 1'b0;
      end
   end

   // next state: registers, divider, source switch, ready, events
   always_comb begin
      next_q = q;
      ev = '0;

      // read data is captured in the setup cycle so the access phase
      // can finish with no wait state and still come from a flop
      if (psel && !penable && !pwrite) begin
         next_q.rdata = rd;
      end

      // new source takes over on an edge of the current one, or at once from a stopped internal one
      next_q.sys_en = cur_tick;

      if (osc_tick) begin
         next_q.dcnt = q.dcnt + 3'h1;
      end
      // divide changes land on a divided boundary, never mid-period
      if (int_tick && (q.div != q.div_act)) begin
         next_q.div_act = q.div;
         next_q.dcnt = 3'h0;
      end

      // switch after the current source's tick; an internal source
      // that is stopped has no edge to wait for
      if ((q.src_sel != q.src_act) && (cur_tick || (!q.src_act && !q.osc_en))) begin
         next_q.src_act = q.src_sel;
         ev[IRQ_SWITCH] = 1'b1;
      end

      // ready after settle ticks; cleared when stopped or recalibrated
      if (!q.osc_en || osc_restart) begin
         next_q.rdy = 1'b0;
         next_q.settle = 4'h0;
      end else if (osc_tick && !q.rdy) begin
         if (q.settle == SETTLE_TICKS - 4'h1) begin
            next_q.rdy = 1'b1;
            ev[IRQ_RDY] = 1'b1;
         end else begin
            next_q.settle = q.settle + 4'h1;
         end
      end

      // register writes, taken in the access phase
      if (wr) begin
         if (paddr == ADDR_SRC_SEL) begin
            // source select; bits 7 to 1 ignored
            next_q.src_sel = pwdata[SRC_BIT];
         end else if (paddr == ADDR_OSC_CTRL) begin
            next_q.osc_en = pwdata[OSC_EN_BIT];
            next_q.div = ioc_div_t'(pwdata[1:0]);
         end else if (paddr == ADDR_OSC_CAL) begin
            next_q.cal = pwdata[CAL_W-1:0];
         end else if (paddr == ADDR_IRQ_MSK) begin
            next_q.msk = pwdata[IRQ_W-1:0];
         end
      end

      // status: write one to clear; an event in the same cycle wins
      if (wr && (paddr == ADDR_IRQ_STS)) begin
         next_q.sts = (q.sts & ~pwdata[IRQ_W-1:0]) | ev;
      end else begin
         next_q.sts = q.sts | ev;
      end
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.osc_en <= RST_OSC_CTRL[OSC_EN_BIT];
         q.div <= ioc_div_t'(RST_OSC_CTRL[1:0]);
         q.div_act <= ioc_div_t'(RST_OSC_CTRL[1:0]);
         // internal source at reset; select resets to zero
         q.src_sel <= RST_SRC_SEL[SRC_BIT];
         q.src_act <= RST_SRC_SEL[SRC_BIT];
         q.cal <= CAL_FACTORY;
      end else begin
         q <= next_q;
      end
   end

   // outputs
   assign prdata = q.rdata;
   assign pready = 1'b1;
   assign pslverr = acc && !mapped;
   assign system_clock_en = q.sys_en;
   assign system_clock_from_ext = q.src_act;
   assign irq = |(q.sts & q.msk);

   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_div8_gap;
      (q.sys_en && !q.src_act && !q.src_sel && (q.div_act == DIV_BY_8))
         |-> ##1 (!q.sys_en) [*7];
   endproperty
   a_div8_gap: assert property (p_div8_gap)
      else $error("divide by 8 tick came early");

   property p_div1_pass;
      (!q.src_act && (q.div_act == DIV_BY_1) && osc_tick) |-> ##1 q.sys_en;
   endproperty
   a_div1_pass: assert property (p_div1_pass)
      else $error("undivided oscillator tick lost");

   property p_no_int_tick;
      (!q.src_act && !int_tick) |-> ##1 !system_clock_en;
   endproperty
   a_no_int_tick: assert property (p_no_int_tick)
      else $error("internal path ticked without divided tick");

   property p_ext_path;
      (q.src_act && ext_osc_tick) |-> ##1 system_clock_en;
   endproperty
   a_ext_path: assert property (p_ext_path)
      else $error("external tick not passed to system clock");

   property p_switch_edge;
      $changed(q.src_act) |-> $past(cur_tick) || !$past(q.osc_en);
   endproperty
   a_switch_edge: assert property (p_switch_edge)
      else $error("source switched away from a source edge");

   property p_osc_stops;
      (!q.osc_en) [*2] |-> !osc_tick && !q.rdy;
   endproperty
   a_osc_stops: assert property (p_osc_stops)
      else $error("oscillator ticking while disabled");

   property p_rdy_event;
      $rose(q.rdy) |-> q.sts[IRQ_RDY] ##1 q.rdy || !q.osc_en;
   endproperty
   a_rdy_event: assert property (p_rdy_event)
      else $error("ready rise did not set status");

   property p_sel_read;
      (psel && !penable && !pwrite && (paddr == ADDR_SRC_SEL))
         |-> ##1 (prdata[31:1] == 31'h0) && (prdata[SRC_BIT] == q.src_sel);
   endproperty
   a_sel_read: assert property (p_sel_read)
      else $error("select register read wrong");

   property p_sel_write;
      (wr && (paddr == ADDR_SRC_SEL)) |-> ##1 (q.src_sel == $past(pwdata[SRC_BIT]));
   endproperty
   a_sel_write: assert property (p_sel_write)
      else $error("select bit not written");

   // divider spacing, reset state, path selection, switching, ready and register access
   property p_div4_gap;
      (q.sys_en && !q.src_act && !q.src_sel && (q.div_act == DIV_BY_4)) |-> ##1 (!q.sys_en) [*3];
   endproperty
   a_div4_gap: assert property (p_div4_gap)
      else $error("divide by 4 tick came early");

   property p_div2_gap;
      (q.sys_en && !q.src_act && !q.src_sel && (q.div_act == DIV_BY_2)) |-> ##1 !q.sys_en;
   endproperty
   a_div2_gap: assert property (p_div2_gap)
      else $error("divide by 2 tick came early");

   property p_div_land;
      $changed(q.div_act) |-> $past(int_tick);
   endproperty
   a_div_land: assert property (p_div_land)
      else $error("divide changed off a divided boundary");

   property p_osc_period;
      (osc_tick && (q.cal != '0)) |-> ##1 !osc_tick;
   endproperty
   a_osc_period: assert property (p_osc_period)
      else $error("oscillator ticked faster than its calibration");

   property p_reset_state;
      $rose(presetn) |-> !q.src_act && (q.div_act == DIV_BY_8) && q.osc_en;
   endproperty
   a_reset_state: assert property (p_reset_state)
      else $error("reset did not leave the internal divided source");

   property p_int_pass;
      (!q.src_act && int_tick) |-> ##1 system_clock_en;
   endproperty
   a_int_pass: assert property (p_int_pass)
      else $error("divided internal tick lost");

   property p_ext_quiet;
      (q.src_act && !ext_osc_tick) |-> ##1 !system_clock_en;
   endproperty
   a_ext_quiet: assert property (p_ext_quiet)
      else $error("external path ticked without an external tick");

   property p_switch_sts;
      $changed(q.src_act) |-> q.sts[IRQ_SWITCH];
   endproperty
   a_switch_sts: assert property (p_switch_sts)
      else $error("source switch did not set status");

   property p_no_req_hold;
      (q.src_sel == q.src_act) |-> ##1 $stable(q.src_act);
   endproperty
   a_no_req_hold: assert property (p_no_req_hold)
      else $error("source moved with no request");

   property p_stop_switch;
      (!q.src_act && q.src_sel && !q.osc_en) |-> ##1 q.src_act;
   endproperty
   a_stop_switch: assert property (p_stop_switch)
      else $error("switch away from a stopped oscillator stalled");

   property p_rdy_drop;
      (q.rdy && !q.osc_en) |-> ##1 !q.rdy;
   endproperty
   a_rdy_drop: assert property (p_rdy_drop)
      else $error("ready stayed up with the oscillator stopped");

   property p_rdy_tick;
      $rose(q.rdy) |-> $past(osc_tick);
   endproperty
   a_rdy_tick: assert property (p_rdy_tick)
      else $error("ready rose without an oscillator tick");

   property p_ctrl_write;
      (wr && (paddr == ADDR_OSC_CTRL)) |-> ##1 (q.osc_en == $past(pwdata[OSC_EN_BIT]));
   endproperty
   a_ctrl_write: assert property (p_ctrl_write)
      else $error("oscillator enable not written");

   property p_ctrl_read;
      (psel && !penable && !pwrite && (paddr == ADDR_OSC_CTRL)) |-> ##1 (prdata[OSC_RDY_BIT] == $past(q.rdy));
   endproperty
   a_ctrl_read: assert property (p_ctrl_read)
      else $error("ready flag read wrong");

endmodule

// ===== rtl/ioc_tick_div.sv
// programmable tick generator standing in for the internal oscillator
// assumes en and restart are synchronous to clk
`timescale 1ns/1ps
module ioc_tick_div
   import ioc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic en,
   input wire logic restart,
   input wire logic [CAL_W-1:0] period,
   // one-cycle pulse every period+1 clocks while enabled
   output logic tick
);

   ioc_div_state_t q;
   ioc_div_state_t next_q;

   // count down and reload; a stopped or restarted oscillator emits nothing
   always_comb begin
      next_q = q;
      next_q.tick = 1'b0;
      if (!en || restart) begin
         next_q.cnt = period;
      end else if (q.cnt == '0) begin
         next_q.tick = 1'b1;
         next_q.cnt = period;
      end else begin
         next_q.cnt = q.cnt - CAL_W'(1);
      end
   end

   // state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign tick = q.tick;

endmodule

// ===== sim/internal_osc_system_clock_select_tb_top.sv
// testbench for the internal oscillator and system clock select block
// assumes the design package and modules are compiled first; one 100 MHz clock
`timescale 1ns/1ps
module internal_osc_system_clock_select_tb_top
   import ioc_pkg::*;
;
   typedef struct packed {
      logic wr;
      logic [APB_AW-1:0] a;
      logic [31:0] wd;
      logic [31:0] exp;
      logic err;
   } ioc_row_t;

   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [APB_AW-1:0] paddr = '0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic ext_osc_tick = 1'b0;
   logic system_clock_en;
   logic system_clock_from_ext;
   logic irq;
   logic ext_run = 1'b0;
   logic [2:0] ext_cnt = 3'h0;
   logic [31:0] rd;
   logic last_err;
   int err_total = 0;
   int checks = 0;
   // reads go after the write, so reserved and read-only bits show up
   ioc_row_t rows [7] = '{
      '{1'b0, ADDR_OSC_CTRL, 32'h0, 32'hC0, 1'b0},
      '{1'b0, ADDR_SRC_SEL, 32'h0, 32'h0, 1'b0},
      '{1'b0, ADDR_OSC_CAL, 32'h0, 32'h3, 1'b0},
      '{1'b1, ADDR_SRC_SEL, 32'h00, 32'h0, 1'b0},
      '{1'b1, ADDR_OSC_CTRL, 32'hBD, 32'hC1, 1'b0},
      '{1'b0, 12'h100, 32'h0, 32'h0, 1'b1},
      '{1'b1, ADDR_OSC_CTRL, 32'hC3, 32'hC3, 1'b0}};

   always #5 pclk = ~pclk;

   // external oscillator stand-in, a tick every 5 bus clocks
   always @(posedge pclk) begin
      ext_cnt <= (ext_cnt == 3'h4) ? 3'h0 : ext_cnt + 3'h1;
      ext_osc_tick <= ext_run && (ext_cnt == 3'h4);
   end

   ioc_system_clock_ctrl i_ioc_system_clock_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_osc_tick(ext_osc_tick),
      .system_clock_en(system_clock_en), .system_clock_from_ext(system_clock_from_ext), .irq(irq));

   task give_verdict;
      $display("checks %0d, mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task chk_word(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
      end
   endtask

   task chk_bit(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
      end
   endtask

   task fail_wait;
      err_total++;
      $display("unexpected at %0t: wait ran out", $time);
      give_verdict;
   endtask

   // one apb transfer; released at the edge that samples pready, then settle
   task apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] wd);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) fail_wait;
      rd = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask

   // third pulse gap, so a pending divide or source change has landed
   task meas(input int exp);
      int n;
      n = 0;
      repeat (3) begin
         n = 0;
         do begin
            @(posedge pclk);
            #1;
            n++;
         end while (system_clock_en !== 1'b1 && n < 400);
         if (n >= 400) fail_wait;
      end
      chk_word(32'(n), 32'(exp));
   endtask

   task wait_src(input logic v);
      int n;
      n = 0;
      while (system_clock_from_ext !== v && n < 200) begin
         @(posedge pclk);
         #1;
         n++;
      end
      chk_bit(system_clock_from_ext, v);
   endtask

   // 60 cycles covers oscillator start plus 8 settle ticks at cal 3
   task do_reset;
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      repeat (60) @(posedge pclk);
      #1;
   endtask

   initial begin
      do_reset;
      foreach (rows[i]) begin
         if (rows[i].wr) apb(1'b1, rows[i].a, rows[i].wd);
         apb(1'b0, rows[i].a, 32'h0);
         chk_word(rd, rows[i].exp);
         chk_bit(last_err, rows[i].err);
      end
      $display("test registers done");
      // every divide code, 4 bus clocks per oscillator tick
      for (int d = 0; d < 4; d++) begin
         apb(1'b1, ADDR_OSC_CTRL, 32'h80 | 32'(d));
         meas(4 * (8 >> d));
      end
      $display("test divide done");
      // the ready event from reset is pending but masked
      apb(1'b0, ADDR_IRQ_STS, 32'h0);
      chk_word(rd, 32'h1);
      chk_bit(irq, 1'b0);
      apb(1'b1, ADDR_IRQ_MSK, 32'h3);
      chk_bit(irq, 1'b1);
      apb(1'b1, ADDR_IRQ_STS, 32'h1);
      chk_bit(irq, 1'b0);
      $display("test irq done");
      // to the external source and back again
      ext_run <= 1'b1;
      apb(1'b1, ADDR_SRC_SEL, 32'h1);
      wait_src(1'b1);
      apb(1'b0, ADDR_IRQ_STS, 32'h0);
      chk_word(rd, 32'h2);
      chk_bit(irq, 1'b1);
      meas(5);
      apb(1'b1, ADDR_IRQ_STS, 32'h2);
      apb(1'b1, ADDR_SRC_SEL, 32'h0);
      wait_src(1'b0);
      meas(4);
      $display("test switch done");
      // a calibration write restarts the oscillator and drops ready
      apb(1'b1, ADDR_OSC_CAL, 32'h1);
      apb(1'b0, ADDR_OSC_CTRL, 32'h0);
      chk_word(rd, 32'h83);
      meas(2);
      repeat (40) @(posedge pclk);
      apb(1'b0, ADDR_OSC_CTRL, 32'h0);
      chk_word(rd, 32'hC3);
      chk_bit(irq, 1'b1);
      $display("test calibrate done");
      // reset in mid-run while the external source is active
      apb(1'b1, ADDR_SRC_SEL, 32'h1);
      wait_src(1'b1);
      do_reset;
      chk_bit(system_clock_from_ext, 1'b0);
      meas(32);
      apb(1'b0, ADDR_OSC_CAL, 32'h0);
      chk_word(rd, 32'h3);
      $display("test reset done");
      give_verdict;
   end
endmodule
